// ### common/cmf_cfg.svh
`ifndef CMF_CFG_SVH
`define CMF_CFG_SVH

// bus geometry
`define CMF_ADDR_W 8
`define CMF_DATA_W 32

// register byte addresses
`define CMF_OFF_PAGE 8'h00
`define CMF_OFF_CTRL 8'h04
`define CMF_OFF_TAG 8'h08
`define CMF_OFF_MASK 8'h0C
`define CMF_OFF_STAMP 8'h10
`define CMF_OFF_MSG 8'h14

// page register fields
`define CMF_PG_IDX_LSB 4
`define CMF_PG_AINC_BIT 7

// control register fields
`define CMF_CT_RXEN_BIT 0
`define CMF_CT_AREP_BIT 1
`define CMF_CT_REPLY_VALID_FLAG_BIT 2
`define CMF_CT_IDE_BIT 3
`define CMF_CT_TXGO_BIT 4
`define CMF_CT_BUSY_BIT 5

// tag and mask layout
`define CMF_RTR_BIT 2
`define CMF_RB1_BIT 1
`define CMF_RB0_BIT 0
`define CMF_IDE_MSK_BIT 0
`define CMF_EXT_LSB 3
`define CMF_STD_LSB 21

// data window and time stamp
`define CMF_IDX_W 3
`define CMF_STAMP_W 16

// bus responses
`define CMF_RESP_OKAY 2'h0
`define CMF_RESP_SLVERR 2'h2

`endif

// ### common/cmf_pkg.sv
package cmf_pkg;

  // receive path states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RECV = 3'h2,
    ST_DROP = 3'h4
  } cmf_rx_state_t;

endpackage

// ### verilog/cmf_fifo.sv
`timescale 1ns/1ps
module cmf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic room;
    logic avail;
  } cmf_fifo_state_t;

  cmf_fifo_state_t s;
  cmf_fifo_state_t next_s;
  logic push;
  logic pop;

  // handshakes on both sides
  assign push = in_valid && s.room;
  assign pop = s.avail && out_ready;
  assign in_ready = s.room;
  assign out_valid = s.avail;
  assign out_data = s.mem[s.rp];

  // pointer and flag update
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
    end
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    next_s.room = next_s.cnt != (AW+1)'(DEPTH);
    next_s.avail = next_s.cnt != '0;
    if (srst) begin
      next_s = '0;
    end
  end

  always_ff @(posedge clk) begin
    s <= next_s;
  end
endmodule

// ### verilog/cmf_filter.sv
`timescale 1ns/1ps
`include "cmf_cfg.svh"
module cmf_filter (
  // stored object tag and mask
  input wire logic [31:0] tag,
  input wire logic [31:0] mask,
  input wire logic ide_tag,
  // received frame fields
  input wire logic [28:0] rx_id,
  input wire logic rx_ide,
  input wire logic rx_rtr,
  // result
  output logic match
);
  logic [28:0] id_en;
  logic id_ok;
  logic rtr_ok;
  logic ide_ok;

  // identifier compare window follows the object's layout
  always_comb begin
    if (ide_tag) begin
      id_en = mask[31:`CMF_EXT_LSB];
    end else begin
      id_en = {mask[31:`CMF_STD_LSB], 18'h00000};
    end
  end

  // masked compares, a 0 mask bit forces true
  assign id_ok = ~|((rx_id ^ tag[31:`CMF_EXT_LSB]) & id_en);
  assign rtr_ok = !mask[`CMF_RTR_BIT] || (rx_rtr == tag[`CMF_RTR_BIT]);
  assign ide_ok = !mask[`CMF_IDE_MSK_BIT] || (rx_ide == ide_tag);
  assign match = id_ok && rtr_ok && ide_ok;
endmodule

// ### verilog/cmf_top.sv
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "cmf_cfg.svh"
module cmf_top #(
  parameter int NUM_OBJ = 4,
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // axi4-lite write address
  input wire logic [`CMF_ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  // axi4-lite write data
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // axi4-lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read address
  input wire logic [`CMF_ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  // axi4-lite read data
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // time stamp tick from bit timing
  input wire logic STAMP_TICK,
  // received frame header
  input wire logic RX_HDR_VALID,
  input wire logic [28:0] RX_ID,
  input wire logic RX_IDE,
  input wire logic RX_RTR,
  input wire logic RX_RB1,
  input wire logic RX_RB0,
  input wire logic RX_EOF,
  // received data bytes
  input wire logic RX_BYTE_VALID,
  input wire logic [7:0] RX_BYTE,
  output logic RX_BYTE_READY,
  // transmit request
  output logic TX_REQ,
  output logic [$clog2(NUM_OBJ)-1:0] TX_OBJ,
  output logic [28:0] TX_ID,
  output logic TX_IDE,
  output logic TX_RTR,
  output logic TX_RB1,
  output logic TX_RB0,
  input wire logic TX_ACK
);
  localparam int OW = $clog2(NUM_OBJ);

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_full;
    logic [`CMF_ADDR_W-1:0] awaddr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [OW-1:0] sel;
    logic [`CMF_IDX_W-1:0] idx;
    logic autoinc;
    logic [NUM_OBJ-1:0][31:0] tag;
    logic [NUM_OBJ-1:0][31:0] mask;
    logic [NUM_OBJ-1:0] ide;
    logic [NUM_OBJ-1:0] rx_en;
    logic [NUM_OBJ-1:0] auto_rep;
    logic [NUM_OBJ-1:0] reply_valid_flag;
    logic [NUM_OBJ-1:0] tx_pend;
    logic [NUM_OBJ-1:0][`CMF_STAMP_W-1:0] stamp;
    logic [NUM_OBJ-1:0][7:0][7:0] data;
    logic [`CMF_STAMP_W-1:0] tstamp;
    cmf_pkg::cmf_rx_state_t st;
    logic [OW-1:0] tgt;
    logic [`CMF_IDX_W-1:0] widx;
    logic tx_req;
    logic [OW-1:0] tx_obj;
    logic [28:0] tx_id;
    logic tx_ide;
    logic tx_rtr;
    logic tx_rb1;
    logic tx_rb0;
  } cmf_state_t;

  cmf_state_t s;
  cmf_state_t next_s;
  logic [NUM_OBJ-1:0] match;
  logic [NUM_OBJ-1:0] hit;
  logic f_valid;
  logic f_ready;
  logic [7:0] f_data;
  logic [OW-1:0] k;
  logic [OW-1:0] j;

  // lowest set index wins among objects
  function automatic logic [OW-1:0] first_set(input logic [NUM_OBJ-1:0] v);
    first_set = '0;
    for (int i = NUM_OBJ - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = OW'(i);
      end
    end
  endfunction

  // merge a strobed word into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] st);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        merge[8*b +: 8] = wd[8*b +: 8];
      end
    end
  endfunction

  // one acceptance filter per object
  for (genvar g = 0; g < NUM_OBJ; g++) begin : g_flt
    cmf_filter u_flt (
      .tag(s.tag[g]),
      .mask(s.mask[g]),
      .ide_tag(s.ide[g]),
      .rx_id(RX_ID),
      .rx_ide(RX_IDE),
      .rx_rtr(RX_RTR),
      .match(match[g])
    );
  end

  assign hit = match & s.rx_en;
  assign k = first_set(hit);
  assign j = first_set(s.tx_pend);
  assign f_ready = s.st != cmf_pkg::ST_IDLE;

  // received bytes wait here until a header picks their object
  cmf_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK),
    .srst(SRST),
    .in_valid(RX_BYTE_VALID),
    .in_ready(RX_BYTE_READY),
    .in_data(RX_BYTE),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // outputs straight from state
  assign AWREADY = s.awready;
  assign WREADY = s.wready;
  assign BVALID = s.bvalid;
  assign BRESP = s.bresp;
  assign ARREADY = s.arready;
  assign RVALID = s.rvalid;
  assign RRESP = s.rresp;
  assign RDATA = s.rdata;
  assign TX_REQ = s.tx_req;
  assign TX_OBJ = s.tx_obj;
  assign TX_ID = s.tx_id;
  assign TX_IDE = s.tx_ide;
  assign TX_RTR = s.tx_rtr;
  assign TX_RB1 = s.tx_rb1;
  assign TX_RB0 = s.tx_rb0;

  // next-state logic
  always_comb begin
    next_s = s;

    // free running time stamp, wraps after 65535
    if (STAMP_TICK) begin
      next_s.tstamp = s.tstamp + 1'b1;
    end

    // transmit launch and completion
    if (s.tx_req && TX_ACK) begin
      next_s.tx_req = 1'b0;
      next_s.stamp[s.tx_obj] = s.tstamp;
    end else if (!s.tx_req && (|s.tx_pend)) begin
      next_s.tx_pend[j] = 1'b0;
      next_s.tx_req = 1'b1;
      next_s.tx_obj = j;
      next_s.tx_id = s.tag[j][31:`CMF_EXT_LSB];
      next_s.tx_ide = s.ide[j];
      next_s.tx_rtr = s.tag[j][`CMF_RTR_BIT];
      next_s.tx_rb1 = s.tag[j][`CMF_RB1_BIT];
      next_s.tx_rb0 = s.tag[j][`CMF_RB0_BIT];
    end

    // write address and data taken independently
    if (AWVALID && s.awready) begin
      next_s.aw_full = 1'b1;
      next_s.awaddr = AWADDR;
    end
    if (WVALID && s.wready) begin
      next_s.w_full = 1'b1;
      next_s.wdata = WDATA;
      next_s.wstrb = WSTRB;
    end
    if (s.bvalid && BREADY) begin
      next_s.bvalid = 1'b0;
    end

    // register write once both halves are held
    if (s.aw_full && s.w_full && !s.bvalid) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `CMF_RESP_OKAY;
      case (s.awaddr)
        `CMF_OFF_PAGE: begin
          if (s.wstrb[0]) begin
            next_s.sel = s.wdata[OW-1:0];
            next_s.idx = s.wdata[`CMF_PG_IDX_LSB +: `CMF_IDX_W];
            next_s.autoinc = s.wdata[`CMF_PG_AINC_BIT];
          end
        end
        `CMF_OFF_CTRL: begin
          if (s.wstrb[0]) begin
            next_s.rx_en[s.sel] = s.wdata[`CMF_CT_RXEN_BIT];
            next_s.auto_rep[s.sel] = s.wdata[`CMF_CT_AREP_BIT];
            next_s.reply_valid_flag[s.sel] = s.wdata[`CMF_CT_REPLY_VALID_FLAG_BIT];
            next_s.ide[s.sel] = s.wdata[`CMF_CT_IDE_BIT];
            if (s.wdata[`CMF_CT_TXGO_BIT]) begin
              next_s.tx_pend[s.sel] = 1'b1;
            end
          end
        end
        `CMF_OFF_TAG: begin
          next_s.tag[s.sel] = merge(s.tag[s.sel], s.wdata, s.wstrb);
        end
        `CMF_OFF_MASK: begin
          next_s.mask[s.sel] = merge(s.mask[s.sel], s.wdata, s.wstrb);
        end
        `CMF_OFF_STAMP: begin
          next_s.bresp = `CMF_RESP_OKAY; // read-only, write dropped
        end
        `CMF_OFF_MSG: begin
          if (s.wstrb[0]) begin
            next_s.data[s.sel][s.idx] = s.wdata[7:0];
            if (s.autoinc) begin
              next_s.idx = s.idx + 1'b1;
            end
          end
        end
        default: begin
          next_s.bresp = `CMF_RESP_SLVERR;
        end
      endcase
    end

    // register read, answered one cycle after the address
    if (s.rvalid && RREADY) begin
      next_s.rvalid = 1'b0;
    end
    if (ARVALID && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = `CMF_RESP_OKAY;
      next_s.rdata = '0;
      case (ARADDR)
        `CMF_OFF_PAGE: begin
          next_s.rdata[OW-1:0] = s.sel;
          next_s.rdata[`CMF_PG_IDX_LSB +: `CMF_IDX_W] = s.idx;
          next_s.rdata[`CMF_PG_AINC_BIT] = s.autoinc;
        end
        `CMF_OFF_CTRL: begin
          next_s.rdata[`CMF_CT_RXEN_BIT] = s.rx_en[s.sel];
          next_s.rdata[`CMF_CT_AREP_BIT] = s.auto_rep[s.sel];
          next_s.rdata[`CMF_CT_REPLY_VALID_FLAG_BIT] = s.reply_valid_flag[s.sel];
          next_s.rdata[`CMF_CT_IDE_BIT] = s.ide[s.sel];
          next_s.rdata[`CMF_CT_BUSY_BIT] = s.tx_pend[s.sel]
            || (s.tx_req && (s.tx_obj == s.sel));
        end
        `CMF_OFF_TAG: begin
          next_s.rdata = s.tag[s.sel];
        end
        `CMF_OFF_MASK: begin
          next_s.rdata = s.mask[s.sel];
        end
        `CMF_OFF_STAMP: begin
          next_s.rdata[15:0] = s.stamp[s.sel];
        end
        `CMF_OFF_MSG: begin
          next_s.rdata[7:0] = s.data[s.sel][s.idx];
          if (s.autoinc) begin
            next_s.idx = next_s.idx + 1'b1;
          end
        end
        default: begin
          next_s.rresp = `CMF_RESP_SLVERR;
        end
      endcase
    end

    // drain received bytes into the target object
    if (f_valid && f_ready && (s.st == cmf_pkg::ST_RECV)) begin
      next_s.data[s.tgt][s.widx] = f_data;
      next_s.widx = s.widx + 1'b1;
    end

    // header acceptance, overrides software writes of the same cycle
    if (RX_HDR_VALID) begin
      if (|hit) begin
        next_s.st = cmf_pkg::ST_RECV;
        next_s.tgt = k;
        next_s.widx = '0;
        next_s.tag[k][31:`CMF_EXT_LSB] = RX_ID;
        next_s.tag[k][`CMF_RTR_BIT] = RX_RTR;
        next_s.tag[k][`CMF_RB1_BIT] = RX_RB1;
        next_s.tag[k][`CMF_RB0_BIT] = RX_RB0;
        next_s.ide[k] = RX_IDE;
        next_s.stamp[k] = s.tstamp;
        // remote frame answered only when the reply is marked valid
        if (s.auto_rep[k] && RX_RTR && s.reply_valid_flag[k]) begin
          next_s.tag[k][`CMF_RTR_BIT] = 1'b0;
          next_s.tx_pend[k] = 1'b1;
        end
      end else begin
        next_s.st = cmf_pkg::ST_DROP;
      end
    end else if (RX_EOF) begin
      next_s.st = cmf_pkg::ST_IDLE;
    end

    // write ready flags follow the held halves, read ready follows the pending read data
    next_s.awready = !next_s.aw_full;
    next_s.wready = !next_s.w_full;
    next_s.arready = !next_s.rvalid;

    if (SRST) begin
      next_s = '0;
      next_s.st = cmf_pkg::ST_IDLE;
    end
  end

  // state register
  always_ff @(posedge CLK) begin
    s <= next_s;
  end
endmodule

// ### dv/cmf_top_sva.sv
`timescale 1ns/1ps
module cmf_top_chk (
  // clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // bus handshakes
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic RVALID,
  input wire logic RREADY,
  // transmit request
  input wire logic TX_REQ,
  input wire logic [28:0] TX_ID,
  input wire logic TX_RTR,
  input wire logic TX_RB1,
  input wire logic TX_RB0,
  input wire logic TX_ACK
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  // bus answers hold and arrive on time
  b_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  b_free_a: assert property (BVALID && BREADY |=> !BVALID && AWREADY && WREADY)
    else $error("write channels not freed");
  w_done_a: assert property (AWVALID && AWREADY && WVALID && WREADY |=> !BVALID ##1 BVALID)
    else $error("write response late");
  r_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable({RDATA, RRESP}))
    else $error("read data dropped early");
  r_answer_a: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
    else $error("read answer late");
  ar_block_a: assert property (RVALID |-> !ARREADY)
    else $error("read address open while data pending");
  // transmit fields stand until acknowledged
  tx_hold_a: assert property (TX_REQ && !TX_ACK |=> TX_REQ && $stable({TX_ID, TX_RTR, TX_RB1, TX_RB0}))
    else $error("transmit request changed before ack");
  tx_end_a: assert property (TX_REQ && TX_ACK |=> !TX_REQ)
    else $error("transmit request held after ack");
  // main scenarios
  cover property (BVALID && BREADY);
  cover property (RVALID && RREADY);
  cover property (TX_REQ && TX_ACK);
endmodule

bind cmf_top cmf_top_chk u_chk (.*);

// ### dv/cmf_can_node.sv
`timescale 1ns/1ps
module cmf_can_node (
  // clock
  input wire logic clk,
  // frame toward the block
  output logic rx_hdr_valid,
  output logic [28:0] rx_id,
  output logic [3:0] rx_flags,
  output logic rx_eof,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  input wire logic rx_byte_ready,
  // frames from the block
  input wire logic tx_req,
  input wire logic [2:0] tx_flags,
  input wire logic [31:0] tx_hdr,
  output logic tx_ack
);
  int ack_wait = 0;
  int wait_cnt = 0;
  int n_tx = 0;
  logic [2:0] seen = 3'h0;
  logic go;
  // object, extension flag and identifier of the last frame sent
  logic [31:0] seen_hdr = 32'h0;
  // byte offers that the block never took
  int n_tmo = 0;

  // idle levels
  initial begin
    rx_hdr_valid = 1'b0;
    rx_id = 29'h0;
    rx_flags = 4'h0;
    rx_eof = 1'b0;
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
    tx_ack = 1'b0;
  end

  // acknowledge after ack_wait cycles, keep the flags sent
  assign go = tx_req && !tx_ack && wait_cnt >= ack_wait;
  always @(posedge clk) begin
    tx_ack <= go;
    wait_cnt <= (tx_req && !tx_ack && !go) ? wait_cnt + 1 : 0;
    if (go) begin
      seen <= tx_flags;
      seen_hdr <= tx_hdr;
      n_tx <= n_tx + 1;
    end
  end

  // header, nb bytes from A0 up, end of frame
  task automatic send_frame(input logic [28:0] id, input logic [3:0] f, input int nb);
    int i;
    int k;
    @(posedge clk);
    rx_hdr_valid <= 1'b1;
    rx_id <= id;
    rx_flags <= f;
    @(posedge clk);
    rx_hdr_valid <= 1'b0;
    rx_id <= ~id;
    rx_flags <= ~f;
    for (i = 0; i < nb; i++) begin
      rx_byte_valid <= 1'b1;
      rx_byte <= 8'hA0 + i[7:0];
      for (k = 0; k < 50; k++) begin
        @(posedge clk);
        if (rx_byte_ready) break;
      end
      if (k == 50) n_tmo++;
    end
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    repeat (30) @(posedge clk);
    rx_eof <= 1'b1;
    @(posedge clk);
    rx_eof <= 1'b0;
  endtask

  // bytes with no header until the buffer refuses
  task automatic fill(output int n);
    int k;
    n = 0;
    @(posedge clk);
    rx_byte_valid <= 1'b1;
    rx_byte <= 8'h40;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (rx_byte_ready) begin
        n++;
        rx_byte <= 8'h40 + n[7:0];
      end
    end
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
  endtask
endmodule

// ### dv/cmf_top_tb_top.sv
`timescale 1ns/1ps
`include "cmf_cfg.svh"
module cmf_top_tb_top;
  localparam logic [28:0] ID = {11'h123, 18'h0};
  localparam logic [28:0] EID = 29'h1555AAA1;
  logic CLK = 1'b0, SRST = 1'b1, STAMP_TICK = 1'b0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00, RX_BYTE;
  logic [31:0] WDATA = 32'h0, RDATA;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, RX_HDR_VALID, RX_IDE, RX_RTR, RX_RB1;
  logic RX_RB0, RX_EOF, RX_BYTE_VALID, RX_BYTE_READY, TX_REQ, TX_IDE, TX_RTR, TX_RB1;
  logic TX_RB0, TX_ACK;
  logic [1:0] BRESP, RRESP, TX_OBJ;
  logic [28:0] RX_ID, TX_ID;
  int err_total = 0, n_checks = 0;

  // block, with the far node beside it
  cmf_top #(.NUM_OBJ(4), .FIFO_DEPTH(16)) dut (.*, .WSTRB(4'hF));
  cmf_can_node node (.clk(CLK), .rx_hdr_valid(RX_HDR_VALID), .rx_id(RX_ID),
    .rx_flags({RX_IDE, RX_RTR, RX_RB1, RX_RB0}), .rx_eof(RX_EOF),
    .rx_byte_valid(RX_BYTE_VALID), .rx_byte(RX_BYTE), .rx_byte_ready(RX_BYTE_READY),
    .tx_req(TX_REQ), .tx_flags({TX_RTR, TX_RB1, TX_RB0}), .tx_ack(TX_ACK),
    .tx_hdr({TX_OBJ, TX_IDE, TX_ID}));

  // clock
  initial begin
    forever #5 CLK = ~CLK;
  end

  task automatic complete_run();
    if (err_total == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tmo(input int k);
    if (k >= 200) begin
      err_total++;
      complete_run();
    end
  endtask

  // bus write and read, each channel held until taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge CLK);
    AWADDR <= a;
    AWVALID <= 1'b1;
    WDATA <= d;
    WVALID <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (BVALID && BREADY) break;
      if (k == 2) BREADY <= 1'b1;
    end
    tmo(k);
    r = BRESP;
    BREADY <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
      if (RVALID && RREADY) break;
      if (k == 1) RREADY <= 1'b1;
    end
    tmo(k);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk(r, `CMF_RESP_OKAY);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(d, e);
    chk(r, `CMF_RESP_OKAY);
  endtask

  task automatic wait_tx(input int n);
    int k;
    for (k = 0; k < 200 && node.n_tx != n; k++) @(posedge CLK);
    tmo(k);
  endtask

  // reset values, read-only stamp, unmapped place
  task automatic sc_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(`CMF_OFF_STAMP, 32'h0);
    wr(`CMF_OFF_STAMP, 32'h0000FFFF);
    rd(`CMF_OFF_STAMP, 32'h0);
    wr(`CMF_OFF_MASK, 32'hFFE00005);
    rd(`CMF_OFF_MASK, 32'hFFE00005);
    axw(8'h18, 32'h1, r);
    chk(r, `CMF_RESP_SLVERR);
    axr(8'h18, d, r);
    chk(d, 32'h0);
    chk(r, `CMF_RESP_SLVERR);
  endtask

  // filter refuses each masked mismatch, then accepts and stamps
  task automatic sc_filter();
    wr(`CMF_OFF_PAGE, 32'h0);
    wr(`CMF_OFF_TAG, 32'h24600000);
    wr(`CMF_OFF_CTRL, 32'h1);
    node.send_frame({11'h122, 18'h0}, 4'h0, 0);
    node.send_frame(ID, 4'h4, 0);
    node.send_frame(ID, 4'h8, 0);
    rd(`CMF_OFF_TAG, 32'h24600000);
    rd(`CMF_OFF_CTRL, 32'h1);
    wr(`CMF_OFF_MASK, 32'hFFE00004);
    repeat (5) begin
      STAMP_TICK <= 1'b1;
      @(posedge CLK);
      STAMP_TICK <= 1'b0;
      @(posedge CLK);
    end
    node.send_frame(ID, 4'h3, 3);
    rd(`CMF_OFF_TAG, 32'h24600003);
    rd(`CMF_OFF_STAMP, 32'h5);
  endtask

  // window index, auto-increment and wrap
  task automatic sc_window();
    wr(`CMF_OFF_PAGE, 32'h80);
    rd(`CMF_OFF_MSG, 32'hA0);
    rd(`CMF_OFF_MSG, 32'hA1);
    rd(`CMF_OFF_MSG, 32'hA2);
    wr(`CMF_OFF_PAGE, 32'hE0);
    wr(`CMF_OFF_MSG, 32'h11);
    wr(`CMF_OFF_MSG, 32'h22);
    wr(`CMF_OFF_MSG, 32'h33);
    wr(`CMF_OFF_PAGE, 32'h00);
    rd(`CMF_OFF_MSG, 32'h33);
    rd(`CMF_OFF_MSG, 32'h33);
    wr(`CMF_OFF_PAGE, 32'h60);
    rd(`CMF_OFF_MSG, 32'h11);
  endtask

  // tag bits go out, automatic reply gated by reply valid
  task automatic sc_tx();
    node.ack_wait = 3;
    wr(`CMF_OFF_CTRL, 32'h11);
    wait_tx(1);
    chk(node.seen, 32'h3);
    chk(node.seen_hdr, {3'h0, ID});
    node.ack_wait = 0;
    wr(`CMF_OFF_TAG, 32'h24600004);
    wr(`CMF_OFF_CTRL, 32'h11);
    wait_tx(2);
    chk(node.seen, 32'h4);
    wr(`CMF_OFF_MASK, 32'hFFE00000);
    wr(`CMF_OFF_CTRL, 32'h07);
    node.send_frame(ID, 4'h4, 0);
    wait_tx(3);
    chk(node.seen, 32'h0);
    wr(`CMF_OFF_CTRL, 32'h03);
    node.send_frame(ID, 4'h4, 0);
    repeat (20) @(posedge CLK);
    chk(node.n_tx, 32'h3);
  endtask

  // buffer filled until it refuses, drained by a header
  task automatic sc_fifo();
    int n;
    wr(`CMF_OFF_CTRL, 32'h01);
    node.fill(n);
    chk(n, 32'h10);
    node.send_frame(ID, 4'h0, 0);
    wr(`CMF_OFF_PAGE, 32'h80);
    rd(`CMF_OFF_MSG, 32'h48);
  endtask

  // extended layout on object 1: 29-bit compare, update and send
  task automatic sc_ext();
    wr(`CMF_OFF_PAGE, 32'h01);
    wr(`CMF_OFF_TAG, 32'hAAAD5508);
    wr(`CMF_OFF_MASK, 32'hFFFFFFF8);
    wr(`CMF_OFF_CTRL, 32'h09);
    node.send_frame(EID ^ 29'h1, 4'h8, 0);
    rd(`CMF_OFF_TAG, 32'hAAAD5508);
    node.send_frame(EID, 4'hB, 0);
    rd(`CMF_OFF_TAG, 32'hAAAD550B);
    rd(`CMF_OFF_CTRL, 32'h09);
    wr(`CMF_OFF_CTRL, 32'h19);
    wait_tx(4);
    chk(node.seen, 32'h3);
    chk(node.seen_hdr, {2'h1, 1'b1, EID});
  endtask

  // reset, then the scenarios
  initial begin
    repeat (20) @(posedge CLK);
    SRST <= 1'b0;
    repeat (2) @(posedge CLK);
    sc_regs();
    sc_filter();
    sc_window();
    sc_tx();
    sc_fifo();
    sc_ext();
    chk(node.n_tmo, 32'h0);
    complete_run();
  end
endmodule
